/* core/uhsc_pkg.sv */
/*
  Package for the single-wire and card-mode transceiver logic: timing constants,
  frame layout, state encodings and the packed carriers shared by the files.
  Assumes a single 10 MHz clock and a baud timebase supplied from outside.
*/
package uhsc_pkg;

  // Clock and baud timing.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned OVERSAMPLE    = 16;
  localparam logic [3:0]  HALF_TICK     = 4'h7;
  localparam logic [3:0]  MID_TICK      = 4'h7;
  localparam logic [3:0]  LAST_TICK     = 4'hF;

  // Frame layout.
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [3:0]  BIT_LAST_DATA = 4'h7;
  localparam logic [3:0]  BIT_PARITY    = 4'h8;
  localparam logic [3:0]  BIT_ZERO      = 4'h0;

  // Stop field encodings.
  localparam logic [1:0]  STOP_ONE      = 2'h0;
  localparam logic [1:0]  STOP_HALF     = 2'h1;
  localparam logic [1:0]  STOP_TWO      = 2'h2;
  localparam logic [1:0]  STOP_ONE_HALF = 2'h3;

  // Guard field and clock prescaler.
  localparam int unsigned GUARD_W       = 8;
  localparam int unsigned PSC_W         = 5;
  localparam logic [4:0]  PSC_OFF       = 5'h00;
  localparam logic [5:0]  DIV_ONE       = 6'h01;

  // NACK acceptance length in baud periods.
  localparam logic [1:0]  NACK_MAX_BITS = 2'h2;

  // Buffer depth.
  localparam int unsigned BUF_DEPTH     = 2;

  typedef enum logic [2:0] {
    UHSC_TX_IDLE  = 3'b000,
    UHSC_TX_DELAY = 3'b001,
    UHSC_TX_START = 3'b011,
    UHSC_TX_DATA  = 3'b010,
    UHSC_TX_PAR   = 3'b110,
    UHSC_TX_STOP  = 3'b111,
    UHSC_TX_GUARD = 3'b101
  } uhsc_tx_state_type;

  typedef enum logic [2:0] {
    UHSC_RX_IDLE  = 3'b000,
    UHSC_RX_START = 3'b001,
    UHSC_RX_DATA  = 3'b011,
    UHSC_RX_PAR   = 3'b010,
    UHSC_RX_STOP  = 3'b110,
    UHSC_RX_NACK  = 3'b111,
    UHSC_RX_QUIET = 3'b101
  } uhsc_rx_state_type;

  // Mode configuration carried as one bundle.
  typedef struct packed {
    logic       single_wire_select;
    logic       card_mode_enable;
    logic       clock_output_enable;
    logic       transmitter_on;
    logic       receiver_on;
    logic       word_length_select;
    logic       parity_enable;
    logic       parity_odd;
    logic [1:0] stop_bit_count;
    logic       parity_nack_enable;
  } uhsc_cfg_type;

  // Received word with its status.
  typedef struct packed {
    logic [7:0] data;
    logic       parity_error;
    logic       framing_error;
    logic       break_seen;
  } uhsc_rx_word_type;

endpackage : uhsc_pkg

/* core/uhsc_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides, holding received words.
  Assumes the drain side may stall for any number of cycles.
*/
`timescale 1ns/10ps
module uhsc_buf (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Fill side
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire uhsc_pkg::uhsc_rx_word_type in_word,
  // Drain side
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output uhsc_pkg::uhsc_rx_word_type     out_word
);

  uhsc_pkg::uhsc_rx_word_type mem_reg [uhsc_pkg::BUF_DEPTH];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_ready  = (count_reg != 2'(uhsc_pkg::BUF_DEPTH));
  assign out_valid = (count_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_word  = mem_reg[rd_ptr_reg];

  genvar i;
  generate
    for (i = 0; i < uhsc_pkg::BUF_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          mem_reg[i] <= '0;
        end else if (push && (wr_ptr_reg == 1'(i))) begin
          mem_reg[i] <= in_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop) count_reg <= count_reg + 2'h1;
      else if (pop && !push) count_reg <= count_reg - 2'h1;
    end
  end

endmodule : uhsc_buf

/* core/uhsc_clkdiv.sv */
/*
  Card clock generator: divides the peripheral clock by twice a 5-bit prescaler.
  Assumes the prescaler is changed only while the card clock is disabled.
*/
`timescale 1ns/10ps
module uhsc_clkdiv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       enable,
  input  wire logic [4:0] prescaler,
  // Card clock
  output logic            card_clock_output
);

  logic [4:0] count_reg;
  logic       clk_out_reg;

  // A half period lasts prescaler cycles, so the ratio is twice the prescaler.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg   <= 5'h00;
      clk_out_reg <= 1'b0;
    end else if (!enable || prescaler == uhsc_pkg::PSC_OFF) begin
      count_reg   <= 5'h00;
      clk_out_reg <= 1'b0;
    end else if (count_reg >= prescaler - 5'h01) begin
      count_reg   <= 5'h00;
      clk_out_reg <= ~clk_out_reg;
    end else begin
      count_reg <= count_reg + 5'h01;
    end
  end

  assign card_clock_output = clk_out_reg;

endmodule : uhsc_clkdiv

/* core/uhsc_core.sv */
/*
  Single-wire half-duplex and card-mode transceiver logic: one shared open-drain
  line, NACK signalling, guard time on transfer complete and a card clock.
  Assumes a 16x oversampling tick from the baud generator and configuration
  held steady while the transceiver is enabled.
*/
// Summary of operation
// - Single-wire mode joins transmit and receive on the transmit pin.
// - Single-wire mode releases the transmit pin whenever no frame is sent.
// - Sending wins; in single-wire and card mode no reception starts while transmitting.
// - A data write with transmitter on starts sending without arbitration.
// - Card mode adds a further half baud delay before shifting starts.
// - On parity error with fractional stops, pull line low one bit if enabled.
// - Card-mode transmit stop: half bit idle, then sample midpoint; low sets framing error.
// - Receiver checks parity in first half stop, then forces low on error.
// - Empty shift register starts guard count; in card mode the completion flag waits for it.
// - Card mode does not change how the completion flag clears.
// - A NACK from the card is not taken as start; one or two bits.
// - The device's own NACK is not taken as a start bit.
// - Break detection is off in card mode; zero bytes are data.
// - No idle frame is sent when the transmit enable toggles in card mode.
// - Card clock is the peripheral clock divided by twice a 5-bit prescaler.
// - Completion flag means transmission fully finished.
`timescale 1ns/10ps
module uhsc_core (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Configuration and baud timebase
  input  wire uhsc_pkg::uhsc_cfg_type    cfg,
  input  wire logic [7:0]                guard_time,
  input  wire logic [4:0]                card_prescaler,
  input  wire logic                      baud_tick,
  // Transmit data write
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  input  wire logic [7:0]                tx_data,
  // Received data
  output logic                           rx_valid,
  input  wire logic                      rx_ready,
  output uhsc_pkg::uhsc_rx_word_type     rx_word,
  // Status
  output logic                           transfer_complete_flag,
  input  wire logic                      transfer_complete_clear,
  output logic                           framing_error_flag,
  input  wire logic                      framing_error_clear,
  output logic                           tx_busy,
  // Line pins
  output logic                           tx_pin_out,
  output logic                           tx_pin_oe_n,
  input  wire logic                      tx_pin_in,
  input  wire logic                      rx_pin_in,
  output logic                           card_clock_output
);

  uhsc_pkg::uhsc_tx_state_type tx_state_reg;
  uhsc_pkg::uhsc_rx_state_type rx_state_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic       tx_par_reg;
  logic       tx_stop_phase_reg;
  logic       tx_nack_reg;
  logic [7:0] guard_cnt_reg;
  logic       tc_reg;
  logic       fe_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_par_reg;
  logic       rx_perr_reg;
  logic [1:0] quiet_bits_reg;
  logic       nack_drive_reg;
  logic       push_reg;
  uhsc_pkg::uhsc_rx_word_type push_word_reg;
  logic       buf_in_ready;

  logic one_wire;
  logic line_in;
  logic tx_bit_end;
  logic rx_bit_end;
  logic rx_mid;
  logic tx_drive_low;
  logic fractional_stop;
  logic load;

  assign one_wire        = cfg.single_wire_select || cfg.card_mode_enable;
  assign line_in         = one_wire ? tx_pin_in : rx_pin_in;
  assign tx_bit_end      = baud_tick && (tx_tick_reg == uhsc_pkg::LAST_TICK);
  assign rx_bit_end      = baud_tick && (rx_tick_reg == uhsc_pkg::LAST_TICK);
  assign rx_mid          = baud_tick && (rx_tick_reg == uhsc_pkg::MID_TICK);
  assign fractional_stop = (cfg.stop_bit_count == uhsc_pkg::STOP_HALF) ||
                           (cfg.stop_bit_count == uhsc_pkg::STOP_ONE_HALF);
  // Writes load the shifter only while idle or in the guard wait; receive storage does not stall it.
  assign tx_ready = cfg.transmitter_on &&
                    (tx_state_reg == uhsc_pkg::UHSC_TX_IDLE ||
                     tx_state_reg == uhsc_pkg::UHSC_TX_GUARD);
  assign load     = tx_valid && tx_ready;
  assign tx_busy  = (tx_state_reg != uhsc_pkg::UHSC_TX_IDLE) &&
                    (tx_state_reg != uhsc_pkg::UHSC_TX_GUARD);

  // Transmit sequencer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state_reg      <= uhsc_pkg::UHSC_TX_IDLE;
      tx_tick_reg       <= 4'h0;
      tx_bit_reg        <= 4'h0;
      tx_shift_reg      <= 8'h00;
      tx_par_reg        <= 1'b0;
      tx_stop_phase_reg <= 1'b0;
      tx_nack_reg       <= 1'b0;
    end else begin
      if (baud_tick) tx_tick_reg <= tx_tick_reg + 4'h1;
      case (tx_state_reg)
        uhsc_pkg::UHSC_TX_IDLE, uhsc_pkg::UHSC_TX_GUARD: begin
          // Enabling the transmitter sends nothing until a word is written.
          if (load) begin
            tx_shift_reg <= tx_data;
            tx_par_reg   <= cfg.parity_odd;
            tx_bit_reg   <= uhsc_pkg::BIT_ZERO;
            tx_tick_reg  <= 4'h0;
            tx_state_reg <= cfg.card_mode_enable ? uhsc_pkg::UHSC_TX_DELAY
                                                 : uhsc_pkg::UHSC_TX_START;
          end else if (tx_state_reg == uhsc_pkg::UHSC_TX_GUARD &&
                       (!cfg.card_mode_enable || guard_cnt_reg >= guard_time)) begin
            tx_state_reg <= uhsc_pkg::UHSC_TX_IDLE;
          end
        end
        uhsc_pkg::UHSC_TX_DELAY: begin
          if (baud_tick && tx_tick_reg == uhsc_pkg::HALF_TICK) begin
            tx_tick_reg  <= 4'h0;
            tx_state_reg <= uhsc_pkg::UHSC_TX_START;
          end
        end
        uhsc_pkg::UHSC_TX_START: begin
          if (tx_bit_end) tx_state_reg <= uhsc_pkg::UHSC_TX_DATA;
        end
        uhsc_pkg::UHSC_TX_DATA: begin
          if (tx_bit_end) begin
            tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == uhsc_pkg::BIT_LAST_DATA) begin
              tx_stop_phase_reg <= 1'b0;
              tx_nack_reg       <= 1'b0;
              tx_state_reg      <= cfg.parity_enable ? uhsc_pkg::UHSC_TX_PAR
                                                     : uhsc_pkg::UHSC_TX_STOP;
            end
          end
        end
        uhsc_pkg::UHSC_TX_PAR: begin
          if (tx_bit_end) tx_state_reg <= uhsc_pkg::UHSC_TX_STOP;
        end
        uhsc_pkg::UHSC_TX_STOP: begin
          // Card stop: half bit doing nothing, then one bit sampled mid-way.
          if (cfg.card_mode_enable && !tx_stop_phase_reg) begin
            if (baud_tick && tx_tick_reg == uhsc_pkg::HALF_TICK) begin
              tx_tick_reg       <= 4'h0;
              tx_stop_phase_reg <= 1'b1;
            end
          end else begin
            if (baud_tick && tx_tick_reg == uhsc_pkg::MID_TICK && !line_in) begin
              tx_nack_reg <= cfg.card_mode_enable;
            end
            if (tx_bit_end) tx_state_reg <= uhsc_pkg::UHSC_TX_GUARD;
          end
        end
        default: tx_state_reg <= uhsc_pkg::UHSC_TX_IDLE;
      endcase
    end
  end
  // Guard counter: clears on each load, steps once per bit while waiting.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      guard_cnt_reg <= 8'h00;
    end else if (load) begin
      guard_cnt_reg <= 8'h00;
    end else if (tx_state_reg == uhsc_pkg::UHSC_TX_GUARD && tx_bit_end &&
                 guard_cnt_reg < guard_time) begin
      guard_cnt_reg <= guard_cnt_reg + 8'h01;
    end
  end
  // Completion flag: set at frame end, after the guard wait in card mode only; clears as usual.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tc_reg <= 1'b1;
    end else if (tx_state_reg == uhsc_pkg::UHSC_TX_GUARD && !load &&
                 (!cfg.card_mode_enable || guard_cnt_reg >= guard_time)) begin
      tc_reg <= 1'b1;
    end else if (transfer_complete_clear || load) begin
      tc_reg <= 1'b0;
    end
  end
  // Framing error flag: set by a NACK at the end of the stop period, or by a stored word with a low stop bit.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fe_reg <= 1'b0;
    end else if ((tx_state_reg == uhsc_pkg::UHSC_TX_STOP && tx_bit_end && tx_nack_reg) ||
                 (push_reg && push_word_reg.framing_error)) begin
      fe_reg <= 1'b1;
    end else if (framing_error_clear) begin
      fe_reg <= 1'b0;
    end
  end

  // Receive sequencer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg   <= uhsc_pkg::UHSC_RX_IDLE;
      rx_tick_reg    <= 4'h0;
      rx_bit_reg     <= 4'h0;
      rx_shift_reg   <= 8'h00;
      rx_par_reg     <= 1'b0;
      rx_perr_reg    <= 1'b0;
      quiet_bits_reg <= 2'h0;
      nack_drive_reg <= 1'b0;
      push_reg       <= 1'b0;
      push_word_reg  <= '0;
    end else begin
      push_reg <= 1'b0;
      if (baud_tick) rx_tick_reg <= rx_tick_reg + 4'h1;
      case (rx_state_reg)
        uhsc_pkg::UHSC_RX_IDLE: begin
          // Sending wins: the receiver stays idle while the line is ours.
          if (cfg.card_mode_enable && tx_state_reg == uhsc_pkg::UHSC_TX_STOP && tx_bit_end) begin
            quiet_bits_reg <= 2'h0;
            rx_state_reg   <= uhsc_pkg::UHSC_RX_QUIET;
          end else if (cfg.receiver_on && !line_in && !(one_wire && tx_busy)) begin
            rx_tick_reg  <= 4'h0;
            rx_state_reg <= uhsc_pkg::UHSC_RX_START;
          end
        end
        uhsc_pkg::UHSC_RX_START: begin
          if (rx_mid && line_in) rx_state_reg <= uhsc_pkg::UHSC_RX_IDLE;
          else if (rx_bit_end) begin
            rx_bit_reg   <= uhsc_pkg::BIT_ZERO;
            rx_par_reg   <= cfg.parity_odd;
            rx_state_reg <= uhsc_pkg::UHSC_RX_DATA;
          end
        end
        uhsc_pkg::UHSC_RX_DATA: begin
          if (rx_mid) begin
            rx_shift_reg <= {line_in, rx_shift_reg[7:1]};
            rx_par_reg   <= rx_par_reg ^ line_in;
          end
          if (rx_bit_end) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == uhsc_pkg::BIT_LAST_DATA) begin
              rx_state_reg <= cfg.parity_enable ? uhsc_pkg::UHSC_RX_PAR
                                                : uhsc_pkg::UHSC_RX_STOP;
              rx_perr_reg  <= 1'b0;
            end
          end
        end
        uhsc_pkg::UHSC_RX_PAR: begin
          if (rx_mid) rx_perr_reg <= rx_par_reg ^ line_in;
          if (rx_bit_end) rx_state_reg <= uhsc_pkg::UHSC_RX_STOP;
        end
        uhsc_pkg::UHSC_RX_STOP: begin
          // Stop sampled mid-bit; a word that cannot be stored waits here.
          if (rx_mid && buf_in_ready) begin
            push_reg                    <= 1'b1;
            push_word_reg.data          <= rx_shift_reg;
            push_word_reg.parity_error  <= rx_perr_reg;
            push_word_reg.framing_error <= !line_in;
            push_word_reg.break_seen    <= !line_in && !cfg.card_mode_enable &&
                                           (rx_shift_reg == 8'h00);
            rx_tick_reg                 <= 4'h0;
            if (cfg.card_mode_enable && rx_perr_reg && cfg.parity_nack_enable &&
                fractional_stop) begin
              nack_drive_reg <= 1'b1;
              rx_state_reg   <= uhsc_pkg::UHSC_RX_NACK;
            end else if (cfg.card_mode_enable) begin
              quiet_bits_reg <= 2'h0;
              rx_state_reg   <= uhsc_pkg::UHSC_RX_QUIET;
            end else begin
              rx_state_reg <= uhsc_pkg::UHSC_RX_IDLE;
            end
          end
        end
        uhsc_pkg::UHSC_RX_NACK: begin
          if (rx_bit_end) begin
            nack_drive_reg <= 1'b0;
            quiet_bits_reg <= 2'h0;
            rx_state_reg   <= uhsc_pkg::UHSC_RX_QUIET;
          end
        end
        uhsc_pkg::UHSC_RX_QUIET: begin
          // Lows after a frame are NACK pulses, ignored up to two bits long.
          if (rx_bit_end) quiet_bits_reg <= quiet_bits_reg + 2'h1;
          if (line_in && quiet_bits_reg != 2'h0) rx_state_reg <= uhsc_pkg::UHSC_RX_IDLE;
          else if (quiet_bits_reg == uhsc_pkg::NACK_MAX_BITS) begin
            rx_state_reg <= uhsc_pkg::UHSC_RX_IDLE;
          end
        end
        default: rx_state_reg <= uhsc_pkg::UHSC_RX_IDLE;
      endcase
    end
  end

  // Pin drive: low only while sending a zero or a NACK; released otherwise.
  always_comb begin
    case (tx_state_reg)
      uhsc_pkg::UHSC_TX_START: tx_drive_low = 1'b1;
      uhsc_pkg::UHSC_TX_DATA:  tx_drive_low = !tx_shift_reg[0];
      uhsc_pkg::UHSC_TX_PAR:   tx_drive_low = !tx_par_reg;
      default:                 tx_drive_low = 1'b0;
    endcase
  end

  assign tx_pin_out  = 1'b0;
  assign tx_pin_oe_n = !(tx_drive_low || nack_drive_reg);
  assign transfer_complete_flag = tc_reg;
  assign framing_error_flag     = fe_reg;

  uhsc_buf u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push_reg),
    .in_ready  (buf_in_ready),
    .in_word   (push_word_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_word  (rx_word)
  );

  uhsc_clkdiv u_clkdiv (
    .clk               (clk),
    .reset             (reset),
    .enable            (cfg.card_mode_enable && cfg.clock_output_enable),
    .prescaler         (card_prescaler),
    .card_clock_output (card_clock_output)
  );

endmodule : uhsc_core

/* tb/uhsc_assertions.sv */
/*
  Port checker for uhsc_core, bound to it from the bench top.
  Assumes the single clock and the active-high asynchronous reset.
*/
`timescale 1ns/10ps
module uhsc_assertions (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Watched ports
  input wire uhsc_pkg::uhsc_cfg_type     cfg,
  input wire logic [4:0]                 card_prescaler,
  input wire logic                       tx_valid,
  input wire logic                       tx_ready,
  input wire logic                       rx_valid,
  input wire logic                       rx_ready,
  input wire uhsc_pkg::uhsc_rx_word_type rx_word,
  input wire logic                       transfer_complete_flag,
  input wire logic                       transfer_complete_clear,
  input wire logic                       framing_error_flag,
  input wire logic                       tx_busy,
  input wire logic                       tx_pin_out,
  input wire logic                       tx_pin_oe_n,
  input wire logic                       card_clock_output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  pin_low_a: assert property (tx_pin_out == 1'b0)
    else $error("transmit pin data is not low");
  single_idle_a: assert property (cfg.single_wire_select && !tx_busy |-> tx_pin_oe_n)
    else $error("line driven with no frame");
  load_start_a: assert property (tx_valid && tx_ready |=> tx_busy && !transfer_complete_flag)
    else $error("write did not start a frame");
  busy_refuse_a: assert property (tx_busy |-> !tx_ready)
    else $error("write accepted mid frame");
  busy_no_done_a: assert property (tx_busy |-> !transfer_complete_flag)
    else $error("complete flag during frame");
  done_hold_a: assert property (transfer_complete_flag && !transfer_complete_clear
      && !(tx_valid && tx_ready) |=> transfer_complete_flag)
    else $error("complete flag dropped on its own");
  clk_off_a: assert property (!cfg.clock_output_enable [*2] |-> !card_clock_output)
    else $error("card clock runs while disabled");
  clk_half_a: assert property (cfg.clock_output_enable && card_prescaler == 5'h03
      && $rose(card_clock_output) |-> card_clock_output [*3] ##1 !card_clock_output)
    else $error("card clock half period wrong");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("stalled word lost or changed");
  load_c: cover property (tx_valid && tx_ready);
  drain_c: cover property (rx_valid && rx_ready);
  nack_c: cover property ($rose(framing_error_flag));
endmodule : uhsc_assertions

/* tb/uhsc_card.sv */
/*
  Behavioural card on the shared open-drain line: sends framed bytes, samples
  frames sent to it and can answer them with a NACK.
  Assumes a pull-up on the line and BIT clocks per bit.
*/
`timescale 1ns/10ps
module uhsc_card #(
  parameter int BIT = 32
) (
  // Clock and shared line
  input  wire logic clk,
  input  wire logic line,
  output logic      rel
);
  logic [8:0] got;
  int         nack_next;
  logic       busy;
  int         low_cyc;
  initial begin
    rel = 1'b1;
    nack_next = 1'b0;
    busy = 1'b0;
  end
  // The tail counts low cycles so the device's NACK can be measured.
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {^d ^ bad, d, 1'b0};
    busy = 1'b1;
    low_cyc = 0;
    for (int i = 0; i < 10; i++) begin
      rel <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rel <= 1'b1;
    repeat (3 * BIT) begin
      @(posedge clk);
      low_cyc += int'(!line);
    end
    busy = 1'b0;
  endtask
  // Its own lows never look like a start, since rel is low then.
  always begin
    @(negedge line);
    if (!busy && rel) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk);
        got[i] = line;
      end
      if (nack_next) begin
        repeat (BIT) @(posedge clk);
        rel <= 1'b0;
        repeat (BIT * nack_next) @(posedge clk);
        rel <= 1'b1;
      end
    end
  end
endmodule : uhsc_card

/* tb/uhsc_tb_top.sv */
/*
  Self-checking bench for uhsc_core with a card model on the shared line.
  Assumes a baud tick every second clock, so one bit is 32 clocks.
*/
`timescale 1ns/10ps
module uhsc_tb_top;
  logic                       clk, reset, tick, tx_valid, tx_ready, rx_valid, rx_ready;
  logic                       tc, tc_clr, fe, fe_clr, busy, oe_n, pin_out, ck_out, rel;
  logic [7:0]                 tx_data, guard;
  logic [4:0]                 psc;
  uhsc_pkg::uhsc_cfg_type     cfg;
  uhsc_pkg::uhsc_rx_word_type rx_word;
  int                         n_fail, num_checks, cyc, n;
  wire                        line = (oe_n | pin_out) & rel;
  uhsc_core uhsc_core_inst (.clk, .reset, .cfg, .guard_time(guard), .card_prescaler(psc),
    .baud_tick(tick), .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_word,
    .transfer_complete_flag(tc), .transfer_complete_clear(tc_clr), .framing_error_flag(fe),
    .framing_error_clear(fe_clr), .tx_busy(busy), .tx_pin_out(pin_out), .tx_pin_oe_n(oe_n),
    .tx_pin_in(line), .rx_pin_in(1'b0), .card_clock_output(ck_out));
  uhsc_card #(.BIT(32)) uhsc_card_inst (.clk, .line, .rel);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) tick <= #1 ~tick;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string s, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic mode(input logic card);
    cfg = '0;
    cfg.single_wire_select = !card;
    cfg.card_mode_enable = card;
    cfg.transmitter_on = 1'b1;
    cfg.receiver_on = 1'b1;
    cfg.word_length_select = 1'b1;
    cfg.parity_enable = 1'b1;
    cfg.stop_bit_count = card ? uhsc_pkg::STOP_ONE_HALF : uhsc_pkg::STOP_ONE;
    cfg.parity_nack_enable = card;
  endtask : mode
  task automatic put(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(posedge clk);
      if (tx_ready === 1'b1) break;
    end
    #1 tx_valid = 1'b0;
  endtask : put
  task automatic wait_tc;
    for (int i = 0; i < 2000 && tc !== 1'b1; i++) @(posedge clk);
    #1;
  endtask : wait_tc
  task automatic get(input logic [10:0] e);
    for (int i = 0; i < 1000 && rx_valid !== 1'b1; i++) @(posedge clk);
    #1;
    chk("received word", e, rx_word);
    rx_ready = 1'b1;
    @(posedge clk);
    #1 rx_ready = 1'b0;
  endtask : get
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    {tx_valid, rx_ready, tc_clr, fe_clr, tick, tx_data} = '0;
    guard = 8'h02;
    psc = 5'h03;
    mode(1'b0);
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    chk("reset flags", 11'h00C, {7'h00, tc, oe_n, fe, rx_valid});
    put(8'hA5);
    wait_tc();
    chk("line word", 11'h0A5, {2'h0, uhsc_card_inst.got});
    chk("own echo", 11'h000, {10'h000, rx_valid});
    tc_clr = 1'b1;
    @(posedge clk);
    #1 tc_clr = 1'b0;
    chk("done cleared", 11'h000, {10'h000, tc});
    $display("test half duplex send done");
    // Three words against a two-entry buffer: the third waits at its stop bit.
    for (int i = 1; i < 4; i++) uhsc_card_inst.send(8'(i * 17), 1'b0);
    for (int i = 1; i < 4; i++) get({8'(i * 17), 3'h0});
    $display("test half duplex receive done");
    mode(1'b1);
    put(8'h5A);
    for (n = 0; n < 99 && oe_n !== 1'b0; n++) @(posedge clk);
    chk("start delay", 11'h001, {10'h000, n inside {[15:20]}});
    for (n = 0; n < 999 && busy !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 999 && tc !== 1'b1; n++) @(posedge clk);
    chk("guard time", 11'h001, {10'h000, n inside {[60:68]}});
    chk("card word", 11'h05A, {2'h0, uhsc_card_inst.got});
    uhsc_card_inst.nack_next = 2;
    #1 put(8'hC3);
    wait_tc();
    chk("nack error", 11'h001, {10'h000, fe});
    chk("nack no start", 11'h000, {10'h000, rx_valid});
    uhsc_card_inst.nack_next = 0;
    fe_clr = 1'b1;
    @(posedge clk);
    #1 fe_clr = 1'b0;
    $display("test card send done");
    uhsc_card_inst.send(8'h66, 1'b1);
    chk("nack length", 11'h020, 11'(uhsc_card_inst.low_cyc));
    get({8'h66, 3'h4});
    chk("own nack start", 11'h000, {10'h000, rx_valid});
    uhsc_card_inst.send(8'h00, 1'b0);
    chk("no nack", 11'h000, 11'(uhsc_card_inst.low_cyc));
    get(11'h000);
    $display("test card receive done");
    cfg.clock_output_enable = 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge clk);
      n += int'(ck_out);
    end
    chk("card clock high", 11'h01E, 11'(n));
    for (int i = 0; i < 9 && ck_out !== 1'b0; i++) @(posedge clk);
    #1 cfg.clock_output_enable = 1'b0;
    psc = 5'h00;
    @(posedge clk);
    #1 cfg.clock_output_enable = 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge clk);
      n += int'(ck_out);
    end
    chk("card clock off", 11'h000, 11'(n));
    $display("test card clock done");
    end_sim();
  end
endmodule : uhsc_tb_top
bind uhsc_core uhsc_assertions uhsc_assertions_inst (.clk, .reset, .cfg, .card_prescaler,
  .tx_valid, .tx_ready, .rx_valid, .rx_ready, .rx_word, .transfer_complete_flag,
  .transfer_complete_clear, .framing_error_flag, .tx_busy, .tx_pin_out, .tx_pin_oe_n,
  .card_clock_output);
